// [verilog/nv_image_pkg.sv]
// Shared constants for the EEPROM image programmer and its host controller.
package nv_image_pkg;
	localparam logic [15:0] ADDR_PROGRAM_COUNT = 16'h0010;
	localparam logic [15:0] ADDR_TARGET_BITS   = 16'h0012;
	localparam logic [15:0] ADDR_OVERLAY_CTRL  = 16'h0014;
	localparam logic [15:0] ADDR_ACTIVE_TARGET = 16'h0013;
	localparam logic [15:0] ADDR_NV_COMMAND    = 16'h00AB;
	localparam logic [15:0] ADDR_PTR_HIGH      = 16'h00AD;
	localparam logic [15:0] ADDR_PTR_LOW       = 16'h00AE;
	localparam logic [15:0] ADDR_SRAM_DATA     = 16'h00B0;
	localparam logic [15:0] ADDR_UNLOCK_KEY    = 16'h00B4;
	localparam int          BIT_PROGRAM        = 0;
	localparam int          BIT_ERASE          = 1;
	localparam int          BIT_BUSY           = 2;
	localparam int          BIT_COMMIT         = 6;
	localparam int          BIT_OVERLAY        = 7;
	localparam logic [7:0]  UNLOCK_KEY_VALUE   = 8'hEA;
	localparam int          IMAGE_DEPTH        = 32;
	localparam logic [12:0] IMG_TARGET_ADDR    = 13'h000C;
	localparam logic [12:0] IMG_REVISION       = 13'h000D;
	localparam logic [12:0] IMG_OVERLAY        = 13'h0000;
	localparam logic [7:0]  TARGET_BITS_RESET  = 8'hC8;
	localparam logic [7:0]  REVISION_RESET     = 8'h00;
	localparam int          ACTIVE_REGS        = 8;
	localparam logic [12:0] IMG_ACTIVE_BASE    = 13'h0010;
	localparam int          CLK_MHZ            = 125;
	localparam int          ERASE_TIME_US      = 10;
	localparam int          PROG_BYTE_TIME_US  = 2;
	localparam int          ERASE_CYCLES       = ERASE_TIME_US * CLK_MHZ;
	localparam int          PROG_BYTE_CYCLES   = PROG_BYTE_TIME_US * CLK_MHZ;
	localparam int          BOOT_SYNC_CYCLES   = 3;
	localparam logic [31:0] APB_ADDR_CMD       = 32'h0000_0000;
	localparam logic [31:0] APB_ADDR_STATUS    = 32'h0000_0004;
	localparam logic [31:0] APB_ADDR_RDATA     = 32'h0000_0008;
	localparam logic [1:0]  OP_WRITE           = 2'h0;
	localparam logic [1:0]  OP_READ            = 2'h1;
	localparam logic [1:0]  OP_PROGRAM         = 2'h2;
endpackage

// [verilog/nv_reg_if.sv]
// Register port joining the host controller to the image programmer.
`timescale 1ns/1ps
interface nv_reg_if (
	input wire logic pclk,
	input wire logic presetn
);
	logic        req;
	logic        wr;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic        ack;
	logic [7:0]  rdata;
	modport device (
		input  pclk,
		input  presetn,
		input  req,
		input  wr,
		input  addr,
		input  wdata,
		output ack,
		output rdata
	);
	modport host (
		input  pclk,
		input  presetn,
		output req,
		output wr,
		output addr,
		output wdata,
		input  ack,
		input  rdata
	);
endinterface

// [verilog/nv_image_device.sv]
// Device end: register port, SRAM staging image, EEPROM programming and power-on load.
//
// Behaviour
// [R1] Commit copies active registers, then self-clears.
// [R2] Commit leaves address and revision bytes alone.
// [R3] Pointer: five high bits plus eight low.
// [R4] Data write stores byte at pointer.
// [R5] Direct SRAM writes never touch active registers.
// [R6] Key 234 unlocks; host relocks with zero.
// [R7] Erase and program issued together; erase first.
// [R8] Program copies whole staging image to EEPROM.
// [R9] Unlock and command writes are back to back.
// [R10] Busy flag set throughout programming.
// [R11] Host waits for busy before locking.
// [R12] Program count increments at next power-on.
// [R13] Overlay bit loads active registers at power-on.
// [R14] Address byte upper five bits, low zero.
// [R15] Active target address bits readable.
// [R16] Special bytes writable only directly.
// [R17] Staging image mirrors EEPROM layout.
// [R18] Overlay replaces only loop and driver settings.
// [R19] Overlay bit defaults to zero.
// [R20] Low address bits from sampled three-level pin.
// [R21] Erase and program commands without the key are ignored; commit needs no key.
`timescale 1ns/1ps
module nv_image_device
	import nv_image_pkg::*;
(
	nv_reg_if.device  bus,
	input wire logic  pin_low,
	input wire logic  pin_high,
	output logic [6:0] target_addr,
	output logic [7:0] active_cfg [ACTIVE_REGS]
);
	typedef enum {ST_BOOT, ST_LOAD, ST_IDLE, ST_COMMIT, ST_ERASE, ST_PROG} state_t;

	state_t      state_q;
	logic [7:0]  sram_q   [IMAGE_DEPTH];
	// EEPROM cells, count and pending flag are non-volatile: presetn leaves them alone.
	logic [7:0]  eeprom_q [IMAGE_DEPTH] = '{IMG_TARGET_ADDR: TARGET_BITS_RESET,
		default: 8'h00}; // [R19]
	logic [7:0]  active_q [ACTIVE_REGS];
	logic [7:0]  count_q = 8'h00;
	logic        pending_q = 1'b0;
	logic [7:0]  key_q;
	logic [12:0] ptr_q;
	logic [7:0]  used_target_q;
	logic [1:0]  low_bits_q;
	logic [15:0] timer_q;
	logic [5:0]  idx_q;
	logic [2:0]  lo_sync_q;
	logic [2:0]  hi_sync_q;
	logic        ack_q;
	logic [7:0]  rdata_q;
	logic        key_armed_q;
	logic        wr_take;

	assign wr_take = bus.req && bus.wr && !ack_q;
	assign bus.ack = ack_q;
	assign bus.rdata = rdata_q;

	// The strap pins pass three flops; only the agreeing last two are trusted.
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			lo_sync_q <= 3'h0;
			hi_sync_q <= 3'h0;
		end else begin
			lo_sync_q <= {lo_sync_q[1:0], pin_low};
			hi_sync_q <= {hi_sync_q[1:0], pin_high};
		end
	end

	// Power-on sequence, commit copy and EEPROM programming share one sequencer.
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			state_q <= ST_BOOT;
			timer_q <= 16'h0000;
			idx_q   <= 6'h00;
		end else begin
			case (state_q)
				ST_BOOT: begin
					// The chain starts cleared, so wait until it holds the real pin level.
					if (idx_q != 6'(BOOT_SYNC_CYCLES)) begin
						idx_q <= idx_q + 6'h01;
					end else if (lo_sync_q[2] == lo_sync_q[1]
						&& hi_sync_q[2] == hi_sync_q[1]) begin
						state_q <= ST_LOAD; // [R20]
					end
				end
				ST_LOAD: state_q <= ST_IDLE;
				ST_IDLE: begin
					if (wr_take && bus.addr == ADDR_NV_COMMAND) begin
						if (bus.wdata[BIT_COMMIT]) begin
							state_q <= ST_COMMIT; // [R1]
						end else if (bus.wdata[BIT_ERASE] && bus.wdata[BIT_PROGRAM]
							&& key_armed_q) begin
							state_q <= ST_ERASE; // [R7] [R21]
							timer_q <= 16'(ERASE_CYCLES);
						end
					end
				end
				ST_COMMIT: state_q <= ST_IDLE;
				ST_ERASE: begin
					if (timer_q == 16'h0000) begin
						state_q <= ST_PROG; // [R7]
						idx_q   <= 6'h00;
						timer_q <= 16'(PROG_BYTE_CYCLES);
					end else begin
						timer_q <= timer_q - 16'h0001;
					end
				end
				ST_PROG: begin
					if (timer_q != 16'h0000) begin
						timer_q <= timer_q - 16'h0001;
					end else if (idx_q == 6'(IMAGE_DEPTH - 1)) begin
						state_q <= ST_IDLE;
					end else begin
						idx_q   <= idx_q + 6'h01;
						timer_q <= 16'(PROG_BYTE_CYCLES);
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge bus.pclk) begin
		if (state_q == ST_ERASE && timer_q == 16'h0000) begin
			for (int i = 0; i < IMAGE_DEPTH; i++) begin
				eeprom_q[i] <= 8'hFF; // [R7]
			end
		end else if (state_q == ST_PROG && timer_q == 16'h0000) begin
			eeprom_q[idx_q[4:0]] <= sram_q[idx_q[4:0]]; // [R8] [R17]
		end
	end

	// Staging image: loaded from EEPROM at power-on, then filled by the commit copy or by pointer-addressed writes.
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			for (int i = 0; i < IMAGE_DEPTH; i++) begin
				sram_q[i] <= 8'h00;
			end
		end else if (state_q == ST_LOAD) begin
			for (int i = 0; i < IMAGE_DEPTH; i++) begin
				sram_q[i] <= eeprom_q[i]; // [R17]
			end
		end else if (state_q == ST_COMMIT) begin
			for (int i = 0; i < ACTIVE_REGS; i++) begin
				sram_q[IMG_ACTIVE_BASE[4:0] + 5'(i)] <= active_q[i]; // [R1] [R2] [R16]
			end
			sram_q[IMG_OVERLAY[4:0]] <= {active_q[0][BIT_OVERLAY], 7'h00};
		end else if (wr_take && bus.addr == ADDR_SRAM_DATA && ptr_q < 13'(IMAGE_DEPTH)) begin
			sram_q[ptr_q[4:0]] <= bus.wdata; // [R4] [R5] [R14]
		end
	end

	// Active registers: slot 0 holds the overlay control; the rest are loop settings.
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			for (int i = 0; i < ACTIVE_REGS; i++) begin
				active_q[i] <= 8'h00; // [R19]
			end
		end else if (state_q == ST_LOAD && eeprom_q[IMG_OVERLAY[4:0]][BIT_OVERLAY]) begin
			active_q[0] <= eeprom_q[IMG_OVERLAY[4:0]]; // [R13]
			for (int i = 1; i < ACTIVE_REGS; i++) begin
				active_q[i] <= eeprom_q[IMG_ACTIVE_BASE[4:0] + 5'(i)]; // [R18]
			end
		end else if (wr_take && bus.addr == ADDR_OVERLAY_CTRL) begin
			active_q[0] <= bus.wdata;
		end else if (wr_take && bus.addr > ADDR_OVERLAY_CTRL
			&& bus.addr < ADDR_OVERLAY_CTRL + 16'(ACTIVE_REGS)) begin
			active_q[bus.addr[2:0] - ADDR_OVERLAY_CTRL[2:0]] <= bus.wdata;
		end
	end

	// Pointer, key, key arming and the address bits that are in use.
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			ptr_q         <= 13'h0000;
			key_q         <= 8'h00;
			key_armed_q   <= 1'b0;
			used_target_q <= 8'h00;
			low_bits_q    <= 2'h0;
		end else begin
			if (wr_take && bus.addr == ADDR_PTR_HIGH) begin
				ptr_q[12:8] <= bus.wdata[4:0]; // [R3]
			end
			if (wr_take && bus.addr == ADDR_PTR_LOW) begin
				ptr_q[7:0] <= bus.wdata; // [R3]
			end
			if (wr_take && bus.addr == ADDR_UNLOCK_KEY) begin
				key_q <= bus.wdata; // [R6]
			end
			// The key only arms the very next write, so any write between disarms it.
			if (wr_take) begin
				key_armed_q <= bus.addr == ADDR_UNLOCK_KEY && bus.wdata == UNLOCK_KEY_VALUE; // [R6] [R9]
			end
			if (state_q == ST_BOOT) begin
				used_target_q <= eeprom_q[IMG_TARGET_ADDR[4:0]]; // [R15]
				low_bits_q    <= lo_sync_q[2] ? 2'h0 : (hi_sync_q[2] ? 2'h1 : 2'h2); // [R20]
			end
		end
	end

	always_ff @(posedge bus.pclk) begin
		if (state_q == ST_LOAD && pending_q) begin
			count_q   <= count_q + 8'h01; // [R12]
			pending_q <= 1'b0;
		end else if (state_q == ST_PROG && timer_q == 16'h0000
			&& idx_q == 6'(IMAGE_DEPTH - 1)) begin
			pending_q <= 1'b1; // [R12]
		end
	end

	// Register reads answer in the cycle after the request is taken.
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			ack_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q <= bus.req && !ack_q;
			if (bus.req && !bus.wr && !ack_q) begin
				case (bus.addr)
					ADDR_PROGRAM_COUNT: rdata_q <= count_q;
					ADDR_TARGET_BITS:   rdata_q <= used_target_q; // [R15]
					ADDR_NV_COMMAND:    rdata_q <= {1'b0, state_q == ST_COMMIT, 3'h0,
						state_q == ST_ERASE || state_q == ST_PROG, 2'h0}; // [R10] [R1]
					ADDR_PTR_HIGH:      rdata_q <= {3'h0, ptr_q[12:8]};
					ADDR_PTR_LOW:       rdata_q <= ptr_q[7:0];
					ADDR_SRAM_DATA:     rdata_q <= sram_q[ptr_q[4:0]];
					ADDR_UNLOCK_KEY:    rdata_q <= key_q;
					default: begin
						if (bus.addr >= ADDR_OVERLAY_CTRL
							&& bus.addr < ADDR_OVERLAY_CTRL + 16'(ACTIVE_REGS)) begin
							rdata_q <= active_q[bus.addr[2:0] - ADDR_OVERLAY_CTRL[2:0]];
						end else begin
							rdata_q <= 8'h00;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			target_addr <= 7'h00;
		end else begin
			target_addr <= {used_target_q[7:3], low_bits_q}; // [R14] [R20]
		end
	end

	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			for (int i = 0; i < ACTIVE_REGS; i++) begin
				active_cfg[i] <= 8'h00;
			end
		end else begin
			active_cfg <= active_q;
		end
	end
endmodule // nv_image_device

// [verilog/nv_image_host.sv]
// Host end: APB-programmed controller that issues register transfers and programming runs.
`timescale 1ns/1ps
module nv_image_host
	import nv_image_pkg::*;
(
	nv_reg_if.host      bus,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0]     prdata,
	output logic            pready,
	output logic            pslverr
);
	typedef enum {H_IDLE, H_XFER, H_UNLOCK, H_CMD, H_POLL, H_LOCK} hstate_t;

	hstate_t     state_q;
	logic [15:0] addr_q;
	logic [7:0]  wdata_q;
	logic [7:0]  rdata_q;
	logic        busy_q;
	logic        req_q;
	logic        wr_q;
	logic        apb_wr;

	// A write takes effect only at the edge where pready is seen high.
	assign apb_wr = psel && penable && pwrite && pready;
	assign bus.req = req_q;
	assign bus.wr = wr_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;

	// Programming runs unlock, command, poll and lock with nothing in between.
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			state_q <= H_IDLE;
			req_q   <= 1'b0;
			wr_q    <= 1'b0;
			addr_q  <= 16'h0000;
			wdata_q <= 8'h00;
			rdata_q <= 8'h00;
		end else begin
			case (state_q)
				H_IDLE: begin
					if (apb_wr && paddr == APB_ADDR_CMD && !busy_q) begin
						if (pwdata[25:24] == OP_PROGRAM) begin
							state_q <= H_UNLOCK; // [R6] [R9]
							addr_q  <= ADDR_UNLOCK_KEY;
							wdata_q <= UNLOCK_KEY_VALUE;
							wr_q    <= 1'b1;
						end else begin
							state_q <= H_XFER;
							addr_q  <= pwdata[23:8];
							wdata_q <= pwdata[7:0];
							wr_q    <= pwdata[25:24] == OP_WRITE;
						end
						req_q <= 1'b1;
					end
				end
				H_XFER: begin
					if (bus.ack) begin
						req_q   <= 1'b0;
						rdata_q <= bus.rdata;
						state_q <= H_IDLE;
					end
				end
				H_UNLOCK: begin
					if (bus.ack) begin
						state_q <= H_CMD; // [R9]
						addr_q  <= ADDR_NV_COMMAND;
						wdata_q <= 8'h03; // [R7]
					end
				end
				H_CMD: begin
					if (bus.ack) begin
						state_q <= H_POLL; // [R10]
						wr_q    <= 1'b0;
					end
				end
				H_POLL: begin
					if (bus.ack && !bus.rdata[BIT_BUSY]) begin
						state_q <= H_LOCK; // [R11]
						addr_q  <= ADDR_UNLOCK_KEY;
						wdata_q <= 8'h00; // [R6]
						wr_q    <= 1'b1;
					end
				end
				H_LOCK: begin
					if (bus.ack) begin
						req_q   <= 1'b0;
						state_q <= H_IDLE;
					end
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= state_q != H_IDLE || (apb_wr && paddr == APB_ADDR_CMD);
		end
	end

	// APB slave answers every access one cycle into the access phase.
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && paddr != APB_ADDR_CMD
				&& paddr != APB_ADDR_STATUS && paddr != APB_ADDR_RDATA;
			if (psel && penable && !pready && !pwrite) begin
				case (paddr)
					APB_ADDR_STATUS: prdata <= {31'h0000_0000, busy_q};
					APB_ADDR_RDATA:  prdata <= {24'h00_0000, rdata_q};
					default:         prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // nv_image_host

// [bench/nv_link_assertions.sv]
// Checker watching the register link between host controller and image programmer.
`timescale 1ns/1ps
module nv_link_assertions
	import nv_image_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        req,
	input wire logic        wr,
	input wire logic [15:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        ack,
	input wire logic [7:0]  rdata
);
	// A run writes every byte after the erase, so it cannot be shorter than this.
	localparam int RUN_MIN = ERASE_CYCLES + (IMAGE_DEPTH - 1) * PROG_BYTE_CYCLES;
	logic        take;
	logic        key_t;
	logic        cmd_t;
	logic        poll_t;
	logic        rd_q;
	logic [15:0] addr_q;
	logic        armed_q;
	logic        run_q;
	logic [15:0] cnt_q;
	logic        lock_t;
	assign take   = req && !ack;
	assign lock_t = take && wr && addr == ADDR_UNLOCK_KEY && wdata == 8'h00;
	assign key_t  = take && wr && addr == ADDR_UNLOCK_KEY && wdata == UNLOCK_KEY_VALUE;
	assign cmd_t  = take && wr && addr == ADDR_NV_COMMAND && wdata[1:0] == 2'h3;
	assign poll_t = ack && rd_q && addr_q == ADDR_NV_COMMAND;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_q    <= 1'b0;
			addr_q  <= 16'h0000;
			armed_q <= 1'b0;
		end else if (take) begin
			rd_q    <= !wr;
			addr_q  <= addr;
			armed_q <= key_t;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
			cnt_q <= 16'h0000;
		end else if (cmd_t && armed_q) begin
			run_q <= 1'b1;
			cnt_q <= 16'h0000;
		end else if (poll_t && !rdata[BIT_BUSY]) begin
			run_q <= 1'b0;
		end else if (run_q && cnt_q != 16'hFFFF) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_cmd;
		cmd_t;
	endsequence
	sequence s_prog_tail;
		ack ##[1:4] s_cmd;
	endsequence
	ack_one_late_a: assert property (take |=> ack)
		else $error("ack missing one cycle after a request");
	ack_single_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	ack_has_cause_a: assert property (ack |-> $past(take))
		else $error("ack without a request");
	unmapped_zero_a: assert property (ack && rd_q && addr_q[15:8] != 8'h00 |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	commit_clear_a: assert property (poll_t |-> !rdata[BIT_COMMIT])
		else $error("commit bit did not clear");
	key_then_cmd_a: assert property (key_t |=> s_prog_tail)
		else $error("command did not follow unlock");
	busy_needs_key_a: assert property (poll_t && rdata[BIT_BUSY] |-> run_q)
		else $error("busy without an unlocked command");
	no_early_lock_a: assert property (lock_t |-> !run_q)
		else $error("lock written while busy");
	run_length_a: assert property (poll_t && !rdata[BIT_BUSY] && run_q |-> cnt_q >= RUN_MIN)
		else $error("programming run too short");
endmodule // nv_link_assertions

// [bench/tb_top.sv]
// Bench joining host and device ends and driving the host over APB.
`timescale 1ns/1ps
module tb_top
	import nv_image_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pin_low, pin_high, pready, pslverr, sl;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [6:0]  target_addr;
	logic [7:0]  active_cfg [ACTIVE_REGS];
	logic [7:0]  cnt;
	int          failures, total_checks;
	nv_reg_if u_nv_reg_if (.pclk(pclk), .presetn(presetn));
	nv_image_device u_nv_image_device (.bus(u_nv_reg_if.device), .pin_low(pin_low),
		.pin_high(pin_high), .target_addr(target_addr), .active_cfg(active_cfg));
	nv_image_host u_nv_image_host (.bus(u_nv_reg_if.host), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	nv_link_assertions u_nv_link_assertions (.pclk(pclk), .presetn(presetn),
		.req(u_nv_reg_if.req), .wr(u_nv_reg_if.wr), .addr(u_nv_reg_if.addr),
		.wdata(u_nv_reg_if.wdata), .ack(u_nv_reg_if.ack), .rdata(u_nv_reg_if.rdata));
	task automatic close_out();
		$display("Checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) begin
			failures++;
			close_out();
		end
	endtask
	// Every host order is followed by status polls, since the host refuses orders while busy.
	task automatic op(input logic [1:0] o, input logic [15:0] a, input logic [7:0] d);
		int n;
		apb(1'b1, APB_ADDR_CMD, {6'h00, o, a, d});
		n = 0;
		do begin
			apb(1'b0, APB_ADDR_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 5000);
		if (n == 5000) begin
			failures++;
			close_out();
		end
	endtask
	task automatic rreg(input logic [15:0] a);
		op(OP_READ, a, 8'h00);
		apb(1'b0, APB_ADDR_RDATA, 32'h0);
	endtask
	task automatic boot(input logic lo, input logic hi);
		pin_low <= lo;
		pin_high <= hi;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
	task automatic t_defaults();
		rreg(ADDR_TARGET_BITS);
		check("target bits", TARGET_BITS_RESET, rd[7:0]);
		check("target addr", {TARGET_BITS_RESET[7:3], 2'h1}, target_addr);
		check("overlay bit", 1'b0, active_cfg[0][BIT_OVERLAY]);
		rreg(ADDR_PROGRAM_COUNT);
		cnt = rd[7:0];
		apb(1'b0, 32'h0000_000C, 32'h0);
		check("pslverr", 1'b1, sl);
		rreg(16'h0100);
		check("unmapped", 8'h00, rd[7:0]);
	endtask
	task automatic t_refused();
		op(OP_WRITE, ADDR_NV_COMMAND, 8'h03);
		rreg(ADDR_NV_COMMAND);
		check("busy no key", 1'b0, rd[BIT_BUSY]);
	endtask
	task automatic t_stage();
		op(OP_WRITE, ADDR_OVERLAY_CTRL, 8'h80);
		op(OP_WRITE, 16'h0015, 8'h5A);
		op(OP_WRITE, ADDR_NV_COMMAND, 8'h40);
		rreg(ADDR_NV_COMMAND);
		check("commit bit", 1'b0, rd[BIT_COMMIT]);
		op(OP_WRITE, ADDR_PTR_HIGH, 8'h00);
		op(OP_WRITE, ADDR_PTR_LOW, 8'h0C);
		op(OP_WRITE, ADDR_SRAM_DATA, 8'h50);
		op(OP_WRITE, ADDR_PTR_LOW, 8'h11);
		op(OP_WRITE, ADDR_SRAM_DATA, 8'h33);
		check("active slot", 8'h5A, active_cfg[1]);
		rreg(ADDR_TARGET_BITS);
		check("bits in use", TARGET_BITS_RESET, rd[7:0]);
		op(OP_WRITE, ADDR_NV_COMMAND, 8'h40);
		op(OP_WRITE, 16'h0015, 8'h11);
	endtask
	task automatic t_program();
		op(OP_PROGRAM, 16'h0000, 8'h00);
		rreg(ADDR_NV_COMMAND);
		check("busy done", 1'b0, rd[BIT_BUSY]);
		rreg(ADDR_UNLOCK_KEY);
		check("key relocked", 8'h00, rd[7:0]);
		boot(1'b1, 1'b0);
		rreg(ADDR_PROGRAM_COUNT);
		check("count", cnt + 8'h01, rd[7:0]);
		rreg(ADDR_TARGET_BITS);
		check("new bits", 8'h50, rd[7:0]);
		check("addr low pin", 7'h28, target_addr);
		check("loaded slot", 8'h5A, active_cfg[1]);
		check("loaded overlay", 1'b1, active_cfg[0][BIT_OVERLAY]);
		boot(1'b0, 1'b0);
		rreg(ADDR_PROGRAM_COUNT);
		check("count kept", cnt + 8'h01, rd[7:0]);
		check("addr mid pin", 7'h2A, target_addr);
	endtask
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pin_low = 1'b0;
		pin_high = 1'b1;
		failures = 0;
		total_checks = 0;
		boot(1'b0, 1'b1);
		t_defaults();
		t_refused();
		t_stage();
		t_program();
		close_out();
	end
endmodule // tb_top
